// file: xmrp_pkg.sv
// shared constants and types for the transceiver and management register ports
package xmrp_pkg;
    // ========================================
    // clock and timing
    localparam int CLK_MHZ = 100;
    localparam int RCFG_MIN_MHZ = 100;
    localparam int RCFG_MAX_MHZ = 125;

    // ========================================
    // transceiver reconfiguration map
    localparam int RCFG_AW = 11;
    localparam int RCFG_DEPTH = 16;
    localparam logic [10:0] RCFG_CAL_EN_OFS = 11'h542;
    localparam int CAL_EN_BIT = 0;
    localparam logic [31:0] CAL_EN_RST = 32'h00000001;

    // ========================================
    // management map
    localparam int MGMT_AW = 16;
    localparam logic [15:0] MGMT_ADAPT_HOLD_OFS = 16'h0343;
    localparam logic [15:0] MGMT_SEQ_STAT_OFS = 16'h0344;
    localparam int ADAPT_HOLD_BIT = 0;
    localparam logic [31:0] ADAPT_HOLD_RST = 32'h00000000;
    localparam int STAT_CAL_BIT = 0;
    localparam int STAT_HOLD_BIT = 1;
    localparam int STAT_VIOL_BIT = 2;
    localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;

    // ========================================
    // management read sequencing
    typedef enum logic [1:0] {RD_IDLE, RD_HOLD, RD_DONE} xmrp_rd_t;

    // reconfiguration side answer
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } xmrp_rcfg_t;

    // management side state
    typedef struct packed {
        xmrp_rd_t rd;
        logic valid;
        logic [31:0] rdata;
        logic [31:0] hold;
        logic viol;
    } xmrp_mgmt_t;
endpackage

// file: xmrp_top.sv
// register ports: transceiver reconfiguration and management csr access
`timescale 1ns/1ps

// Behaviour
// (R01) reconfiguration port sampled and driven on the single clock only
// (R02) reconfiguration reset clears port logic and all registers behind it; the calibration register at 0x542 loads 1 instead
// (R03) write and read requests are active high
// (R04) reconfiguration write stores 32-bit data at the addressed register
// (R05) read data holds addressed register, valid once wait drops
// (R06) host holds request, address, data while wait is high
// (R07) host sets adaptation hold bit 0x343[0] before transceiver access
// (R08) host clears calibration bit 0x542[0] before other transceiver access
// (R09) host sets calibration bit 0x542[0] again after its accesses
// (R10) host clears adaptation hold bit 0x343[0] as final step
// (R11) management port answers during any reset but the register bank one
// (R12) bank reset clears registers; management port silent during it
// (R13) host issues no new read until previous read data returned
// (R14) management port synchronous to the 100 MHz clock
// (R15) legacy management reset input tied to zero by integrator
// (R16) management decodes 16-bit address qualified by read or write
// (R17) management read data meaningful only while valid strobe high
// (R18) management wait stalls reads only, never writes
// (R19) unused management write bytes sit in low-order byte lanes
// (R20) exactly one valid pulse per accepted read, data stable then
module xmrp_top #(
    parameter int RCFG_AW = xmrp_pkg::RCFG_AW,
    parameter int RCFG_DEPTH = xmrp_pkg::RCFG_DEPTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic reconfig_reset,
    input wire logic reconfig_write,
    input wire logic reconfig_read,
    input wire logic [RCFG_AW-1:0] reconfig_address,
    input wire logic [31:0] reconfig_writedata,
    output logic [31:0] reconfig_readdata,
    output logic reconfig_waitrequest,
    input wire logic csr_rst_b,
    input wire logic reset_status,
    input wire logic [15:0] status_addr,
    input wire logic status_read,
    input wire logic status_write,
    input wire logic [31:0] status_writedata,
    output logic [31:0] status_readdata,
    output logic status_readdata_valid,
    output logic status_waitrequest,
    output logic cal_enable,
    output logic adapt_hold
);
    // ========================================
    // state
    typedef struct packed {
        xmrp_pkg::xmrp_rcfg_t rc;
        logic [31:0] cal;
        logic [RCFG_DEPTH-1:0][31:0] mem;
        xmrp_pkg::xmrp_mgmt_t mg;
    } xmrp_state_t;

    xmrp_state_t s_r;
    xmrp_state_t s_nxt;

    // ========================================
    // decode helpers
    function automatic logic rc_in_mem(input logic [RCFG_AW-1:0] a);
        rc_in_mem = (32'(a) < RCFG_DEPTH);
    endfunction

    function automatic logic [31:0] rc_rdval(input xmrp_state_t s,
                                             input logic [RCFG_AW-1:0] a);
        if (a == RCFG_AW'(xmrp_pkg::RCFG_CAL_EN_OFS))
            rc_rdval = s.cal;
        else if (rc_in_mem(a))
            rc_rdval = s.mem[a];
        else
            rc_rdval = xmrp_pkg::UNMAPPED_DATA;
    endfunction

    function automatic logic [31:0] mg_rdval(input xmrp_state_t s,
                                             input logic [15:0] a);
        logic [31:0] st;
        st = 32'h00000000;
        st[xmrp_pkg::STAT_CAL_BIT] = s.cal[xmrp_pkg::CAL_EN_BIT];
        st[xmrp_pkg::STAT_HOLD_BIT] = s.mg.hold[xmrp_pkg::ADAPT_HOLD_BIT];
        st[xmrp_pkg::STAT_VIOL_BIT] = s.mg.viol;
        if (a == xmrp_pkg::MGMT_ADAPT_HOLD_OFS)
            mg_rdval = s.mg.hold;
        else if (a == xmrp_pkg::MGMT_SEQ_STAT_OFS)
            mg_rdval = st;
        else
            mg_rdval = xmrp_pkg::UNMAPPED_DATA;
    endfunction

    // ========================================
    // request qualification
    logic rc_wr;
    logic rc_rd_done;
    logic rc_mem_hit;
    logic mg_live;
    logic mg_wr;
    logic mg_rd_take;

    // reset_status is a legacy pin and has no effect; see (R15)
    assign rc_wr = reconfig_write & ~reconfig_reset; // see (R03)
    assign rc_rd_done = reconfig_read & s_r.rc.ack & ~reconfig_reset;
    assign rc_mem_hit = rc_in_mem(reconfig_address) &
        (rc_wr | rc_rd_done);
    assign mg_live = csr_rst_b; // see (R11)
    assign mg_wr = status_write & mg_live; // see (R16)
    assign mg_rd_take = status_read & mg_live & (s_r.mg.rd == xmrp_pkg::RD_HOLD);

    // ========================================
    // next state
    always_comb
    begin
        s_nxt = s_r;
        // reconfiguration port: reads take one wait cycle
        s_nxt.rc.ack = 1'b0;
        if (reconfig_read & ~s_r.rc.ack)
        begin
            s_nxt.rc.ack = 1'b1;
            s_nxt.rc.rdata = rc_rdval(s_r, reconfig_address); // see (R05)
        end
        if (rc_wr)
        begin
            if (reconfig_address == RCFG_AW'(xmrp_pkg::RCFG_CAL_EN_OFS))
                s_nxt.cal = reconfig_writedata; // see (R04)
            else if (rc_in_mem(reconfig_address))
                s_nxt.mem[reconfig_address] = reconfig_writedata; // see (R04)
        end
        if (reconfig_reset)
        begin
            s_nxt.rc = '0; // see (R02)
            s_nxt.cal = xmrp_pkg::CAL_EN_RST;
            s_nxt.mem = '0;
        end

        // management port
        s_nxt.mg.valid = 1'b0;
        unique case (s_r.mg.rd)
            xmrp_pkg::RD_IDLE:
                if (status_read & mg_live)
                begin
                    s_nxt.mg.rd = xmrp_pkg::RD_HOLD;
                end
            xmrp_pkg::RD_HOLD:
                if (mg_rd_take)
                begin
                    s_nxt.mg.rd = xmrp_pkg::RD_DONE;
                    s_nxt.mg.rdata = mg_rdval(s_r, status_addr);
                end
            xmrp_pkg::RD_DONE:
            begin
                s_nxt.mg.valid = 1'b1; // see (R20)
                s_nxt.mg.rd = xmrp_pkg::RD_IDLE;
            end
            // the spare code would otherwise lock the read port up
            default:
                s_nxt.mg.rd = xmrp_pkg::RD_IDLE;
        endcase
        if (mg_wr)
        begin
            // narrow writers leave low lanes empty; all fields here sit in bits 0 and 2 of low byte lane 0
            // see (R19)
            if (status_addr == xmrp_pkg::MGMT_ADAPT_HOLD_OFS)
                s_nxt.mg.hold = status_writedata;
            if (status_addr == xmrp_pkg::MGMT_SEQ_STAT_OFS &&
                status_writedata[xmrp_pkg::STAT_VIOL_BIT])
                s_nxt.mg.viol = 1'b0;
        end
        // mem access with calibration running breaks the freeze sequence;
        // setting after the clear makes a same-cycle event win
        if (rc_mem_hit & s_r.cal[xmrp_pkg::CAL_EN_BIT]) // see (R08)
            s_nxt.mg.viol = 1'b1;
        if (~csr_rst_b)
        begin
            s_nxt.mg = '0; // see (R12)
            s_nxt.mg.hold = xmrp_pkg::ADAPT_HOLD_RST;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_r <= '0;
            s_r.cal <= xmrp_pkg::CAL_EN_RST;
            s_r.mg.hold <= xmrp_pkg::ADAPT_HOLD_RST;
        end
        else
            s_r <= s_nxt; // see (R01) (R14)
    end

    // ========================================
    // outputs
    assign reconfig_readdata = s_r.rc.rdata;
    assign reconfig_waitrequest = reconfig_reset |
        (reconfig_read & ~s_r.rc.ack); // see (R06)
    assign status_readdata = s_r.mg.rdata; // see (R17)
    assign status_readdata_valid = s_r.mg.valid;
    // writes never see wait; silent bank reset keeps reads stalled
    assign status_waitrequest = status_read &
        (~mg_live | (s_r.mg.rd != xmrp_pkg::RD_HOLD)); // see (R18) (R12)
    assign cal_enable = s_r.cal[xmrp_pkg::CAL_EN_BIT];
    assign adapt_hold = s_r.mg.hold[xmrp_pkg::ADAPT_HOLD_BIT];

    // ========================================
    // checks: reconfiguration port
    a_rc_read_wait: assert property ( // see (R05)
        @(posedge clk) disable iff (!rst_b)
        (reconfig_read && !reconfig_reset && !s_r.rc.ack) |->
        reconfig_waitrequest ##1 s_r.rc.ack)
        else $error("reconfig read did not stall exactly one cycle");

    a_rc_rd_data: assert property ( // see (R05)
        @(posedge clk) disable iff (!rst_b)
        (reconfig_read && !reconfig_waitrequest &&
         reconfig_address == RCFG_AW'(xmrp_pkg::RCFG_CAL_EN_OFS)) |->
        (reconfig_readdata == s_r.cal))
        else $error("reconfig read data differs from register");

    a_rc_wr_store: assert property ( // see (R04)
        @(posedge clk) disable iff (!rst_b)
        (reconfig_write && !reconfig_reset &&
         reconfig_address == RCFG_AW'(xmrp_pkg::RCFG_CAL_EN_OFS)) |=>
        (s_r.cal == $past(reconfig_writedata)))
        else $error("calibration register write lost");

    a_rc_reset: assert property ( // see (R02)
        @(posedge clk) disable iff (!rst_b)
        reconfig_reset |=> (s_r.cal == xmrp_pkg::CAL_EN_RST &&
        s_r.mem == '0 && !s_r.rc.ack))
        else $error("reconfig reset did not clear port state");

    a_rc_rst_wait: assert property ( // see (R02)
        @(posedge clk) disable iff (!rst_b)
        reconfig_reset |-> reconfig_waitrequest)
        else $error("reconfig port not stalled during its reset");

    a_rc_wr_nowait: assert property ( // see (R03)
        @(posedge clk) disable iff (!rst_b)
        (reconfig_write && !reconfig_read && !reconfig_reset) |->
        !reconfig_waitrequest)
        else $error("reconfig write stalled");

    a_rc_idle_nowait: assert property ( // see (R06)
        @(posedge clk) disable iff (!rst_b)
        (!reconfig_read && !reconfig_reset) |-> !reconfig_waitrequest)
        else $error("reconfig wait raised with no read pending");

    // ========================================
    // checks: management port
    a_mg_wr_nowait: assert property ( // see (R18)
        @(posedge clk) disable iff (!rst_b)
        (status_write && !status_read) |-> !status_waitrequest)
        else $error("management write stalled");

    a_mg_wait_rdonly: assert property ( // see (R18)
        @(posedge clk) disable iff (!rst_b)
        !status_read |-> !status_waitrequest)
        else $error("management wait raised without a read");

    a_mg_rd_valid: assert property ( // see (R20)
        @(posedge clk) disable iff (!rst_b)
        (status_read && !status_waitrequest && csr_rst_b) |=>
        !status_readdata_valid ##1 status_readdata_valid ##1
        !status_readdata_valid)
        else $error("read valid not a single pulse two cycles on");

    a_mg_valid_cause: assert property ( // see (R20)
        @(posedge clk) disable iff (!rst_b)
        status_readdata_valid |-> $past(s_r.mg.rd == xmrp_pkg::RD_DONE))
        else $error("read valid without a taken read");

    a_mg_bank_rst: assert property ( // see (R12)
        @(posedge clk) disable iff (!rst_b)
        !csr_rst_b |-> ##1 (s_r.mg.hold == xmrp_pkg::ADAPT_HOLD_RST &&
        !status_readdata_valid))
        else $error("bank reset did not silence management port");

    a_mg_bank_wait: assert property ( // see (R12)
        @(posedge clk) disable iff (!rst_b)
        (!csr_rst_b && status_read) |-> status_waitrequest)
        else $error("management read answered during bank reset");

    a_mg_rd_data: assert property ( // see (R17)
        @(posedge clk) disable iff (!rst_b)
        (status_read && !status_waitrequest &&
         status_addr == xmrp_pkg::MGMT_ADAPT_HOLD_OFS) |->
        ##2 (status_readdata_valid &&
        status_readdata == $past(s_r.mg.hold, 2)))
        else $error("management read data wrong");

    a_mg_hold_wr: assert property ( // see (R16)
        @(posedge clk) disable iff (!rst_b)
        (status_write && csr_rst_b &&
         status_addr == xmrp_pkg::MGMT_ADAPT_HOLD_OFS) |=>
        (s_r.mg.hold == $past(status_writedata)))
        else $error("adaptation hold write lost");

    a_viol_set: assert property ( // see (R08)
        @(posedge clk) disable iff (!rst_b)
        (rc_mem_hit && cal_enable && csr_rst_b) |=> s_r.mg.viol)
        else $error("calibration violation not flagged");

    a_viol_clear: assert property ( // see (R08)
        @(posedge clk) disable iff (!rst_b)
        (status_write && csr_rst_b && !rc_mem_hit &&
         status_addr == xmrp_pkg::MGMT_SEQ_STAT_OFS &&
         status_writedata[xmrp_pkg::STAT_VIOL_BIT]) |=> !s_r.mg.viol)
        else $error("calibration violation flag not cleared");
endmodule

// file: xmrp_host.sv
// host bus master model for the reconfiguration and management ports
`timescale 1ns/1ps
module xmrp_host (
    input wire logic clk,
    output logic reconfig_write,
    output logic reconfig_read,
    output logic [10:0] reconfig_address,
    output logic [31:0] reconfig_writedata,
    input wire logic [31:0] reconfig_readdata,
    input wire logic reconfig_waitrequest,
    output logic reset_status,
    output logic [15:0] status_addr,
    output logic status_read,
    output logic status_write,
    output logic [31:0] status_writedata,
    input wire logic [31:0] status_readdata,
    input wire logic status_readdata_valid,
    input wire logic status_waitrequest
);
    int n;
    // ========================================
    // idle bus
    initial
    begin
        {reconfig_write, reconfig_read, status_read, status_write} = 4'h0;
        reconfig_address = 11'h000;
        reconfig_writedata = 32'h00000000;
        status_addr = 16'h0000;
        status_writedata = 32'h00000000;
        reset_status = 1'b0;
    end
    // ========================================
    // transfers; released address and data lines show the inverse, not the old value
    task automatic rc_xfer(input logic wr, input logic [10:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic ok);
        @(posedge clk);
        reconfig_write <= wr;
        reconfig_read <= ~wr;
        reconfig_address <= a;
        reconfig_writedata <= d;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (reconfig_waitrequest && n < 40);
        ok = !reconfig_waitrequest;
        q = reconfig_readdata;
        @(posedge clk);
        reconfig_write <= 1'b0;
        reconfig_read <= 1'b0;
        reconfig_address <= ~a;
        reconfig_writedata <= ~d;
    endtask
    // a read returns once its data came back, or once its wait or valid wait timed out: one read in flight
    task automatic st_xfer(input logic wr, input logic [15:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic ok);
        @(posedge clk);
        status_write <= wr;
        status_read <= ~wr;
        status_addr <= a;
        status_writedata <= d;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (status_waitrequest && n < 40);
        ok = !status_waitrequest;
        q = 32'h00000000;
        @(posedge clk);
        status_write <= 1'b0;
        status_read <= 1'b0;
        status_addr <= ~a;
        status_writedata <= ~d;
        n = 0;
        while (!wr && ok && !status_readdata_valid && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        // data counts only in the cycle its valid strobe stands
        if (!wr)
        begin
            ok = ok && status_readdata_valid;
            q = status_readdata;
        end
    endtask
endmodule

// file: test_xcvr_and_mgmt_register_ports.sv
// self-checking testbench for the register ports block
`timescale 1ns/1ps
module test_xcvr_and_mgmt_register_ports;
    logic clk, rst_b, reconfig_reset, csr_rst_b, reset_status;
    logic reconfig_write, reconfig_read, reconfig_waitrequest;
    logic [10:0] reconfig_address;
    logic [31:0] reconfig_writedata, reconfig_readdata, q;
    logic [15:0] status_addr;
    logic status_read, status_write, status_readdata_valid;
    logic status_waitrequest, cal_enable, adapt_hold, ok;
    logic [31:0] status_writedata, status_readdata;
    int errors, checked;
    xmrp_top i_xmrp_top (.clk, .rst_b, .reconfig_reset, .reconfig_write,
        .reconfig_read, .reconfig_address, .reconfig_writedata,
        .reconfig_readdata, .reconfig_waitrequest, .csr_rst_b,
        .reset_status, .status_addr, .status_read, .status_write,
        .status_writedata, .status_readdata, .status_readdata_valid,
        .status_waitrequest, .cal_enable, .adapt_hold);
    xmrp_host i_xmrp_host (.clk, .reconfig_write, .reconfig_read,
        .reconfig_address, .reconfig_writedata, .reconfig_readdata,
        .reconfig_waitrequest, .reset_status, .status_addr, .status_read,
        .status_write, .status_writedata, .status_readdata,
        .status_readdata_valid, .status_waitrequest);
    // ========================================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // writes land on the release edge; look only once it has settled
    task automatic rcw(input logic [10:0] a, input logic [31:0] d);
        i_xmrp_host.rc_xfer(1'b1, a, d, q, ok);
        @(negedge clk);
    endtask
    task automatic rcr(input logic [10:0] a);
        i_xmrp_host.rc_xfer(1'b0, a, 32'h00000000, q, ok);
    endtask
    task automatic stw(input logic [15:0] a, input logic [31:0] d);
        i_xmrp_host.st_xfer(1'b1, a, d, q, ok);
        @(negedge clk);
    endtask
    task automatic str(input logic [15:0] a);
        i_xmrp_host.st_xfer(1'b0, a, 32'h00000000, q, ok);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ========================================
    // scenarios
    task automatic t_reset_vals();
        check({30'h0, adapt_hold, cal_enable}, 32'h1);
        rcr(11'h542);
        check(q, 32'h1);
        str(16'h0343);
        check(q, 32'h0);
        str(16'h0100);
        check(q, 32'h0);
    endtask
    task automatic t_sequence();
        stw(16'h0343, 32'h1);
        check({31'h0, ok}, 32'h1);
        check({31'h0, adapt_hold}, 32'h1);
        rcw(11'h542, 32'h0);
        check({31'h0, cal_enable}, 32'h0);
        rcw(11'h003, 32'hA5C30F12);
        rcw(11'h004, 32'h00000001);
        rcr(11'h003);
        check(q, 32'hA5C30F12);
        rcw(11'h542, 32'h1);
        stw(16'h0343, 32'h0);
        str(16'h0344);
        check(q, 32'h1);
        @(negedge clk);
        check({31'h0, status_readdata_valid}, 32'h0);
    endtask
    // array write with calibration still on marks the sticky flag
    task automatic t_violation();
        rcw(11'h005, 32'h12345678);
        str(16'h0344);
        check(q, 32'h5);
        stw(16'h0344, 32'h4);
        str(16'h0344);
        check(q, 32'h1);
    endtask
    // reset pins move on a rising edge, like every other input
    task automatic t_resets();
        rcw(11'h542, 32'h0);
        @(posedge clk);
        reconfig_reset <= 1'b1;
        rcw(11'h003, 32'hFFFFFFFF);
        check({31'h0, ok}, 32'h0);
        str(16'h0343);
        check({31'h0, ok}, 32'h1);
        @(posedge clk);
        reconfig_reset <= 1'b0;
        rcr(11'h542);
        check(q, 32'h1);
        rcr(11'h003);
        check(q, 32'h0);
        stw(16'h0343, 32'h1);
        @(posedge clk);
        csr_rst_b <= 1'b0;
        str(16'h0343);
        check({31'h0, ok}, 32'h0);
        @(posedge clk);
        csr_rst_b <= 1'b1;
        @(negedge clk);
        check({31'h0, adapt_hold}, 32'h0);
        str(16'h0343);
        check(q, 32'h0);
    endtask
    // ========================================
    // clock, main sequence, watchdog
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        errors = 0;
        checked = 0;
        rst_b = 1'b0;
        reconfig_reset = 1'b0;
        csr_rst_b = 1'b1;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        t_reset_vals();
        t_sequence();
        t_violation();
        t_resets();
        wrap_up();
    end
    initial
    begin
        #100us;
        errors++;
        wrap_up();
    end
endmodule
